// ---- include/floppy_port_pkg.sv ----
/*
  constants, field layouts and carrier types for the floppy host register port.
  assumes a single 250 MHz clock and a host that honours the ready/direction handshake.
*/
// Operation
// - status bit 7 says the byte port may take or give a byte
// - every byte port access drops ready until the next byte can move; the code drops it only for accepted bytes, not for refused accesses
// - status bit 6 reads 1 for device-to-host, 0 for host writes
// - status bit 5 non-DMA flag only during execution phase
// - status bit 4 busy while executing; bits 3 and 2 reserved
// - status bits 1 and 0 flag drive B and drive A seeking
// - control bits 7 to 4 enable motors D, C, B, A
// - control bit 3 enables interrupt and DMA requests to host
// - control bit 2 low holds floppy function in reset
// - control bit 1 picks C or D, bit 0 picks A or B
// - control register is write-only and cleared by channel reset
// - rate bits 1:0 pick 500, 300, 250 kbit/s; 11 reserved
// - channel reset clears rate register; bits 7 to 2 unused
// - byte port steps through command and result bytes one at a time
// - busy during execution, then host reads result bytes with same handshake
// - decode control, status, data, rate at primary or secondary base
// - accept the listed floppy commands; others are invalid
// - first result byte top bits carry the termination code
package floppy_port_pkg;
  localparam logic [9:0] PRI_CTRL_ADDR   = 10'h3f2;
  localparam logic [9:0] PRI_STATUS_ADDR = 10'h3f4;
  localparam logic [9:0] PRI_DATA_ADDR   = 10'h3f5;
  localparam logic [9:0] PRI_RATE_ADDR   = 10'h3f7;
  localparam logic [9:0] SEC_CTRL_ADDR   = 10'h372;
  localparam logic [9:0] SEC_STATUS_ADDR = 10'h374;
  localparam logic [9:0] SEC_DATA_ADDR   = 10'h375;
  localparam logic [9:0] SEC_RATE_ADDR   = 10'h377;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [1:0] RATE_RESET      = 2'h0;
  localparam int         STAT_READY_BIT  = 7;
  localparam int         STAT_DIR_BIT    = 6;
  localparam int         STAT_NONDMA_BIT = 5;
  localparam int         STAT_BUSY_BIT   = 4;
  localparam int         CTRL_DMAEN_BIT  = 3;
  localparam int         CTRL_RUN_BIT    = 2;
  localparam logic [1:0] normal_completion = 2'h0;
  localparam logic [1:0] abrupt_completion = 2'h1;
  localparam logic [1:0] INVALID_CODE      = 2'h2;
  localparam logic [4:0] OP_READ_DATA  = 5'h06;
  localparam logic [4:0] OP_FORMAT     = 5'h0d;
  localparam logic [4:0] OP_SCAN_EQ    = 5'h11;
  localparam logic [4:0] OP_SCAN_LE    = 5'h19;
  localparam logic [4:0] OP_SCAN_HE    = 5'h1d;
  localparam logic [4:0] OP_RECAL      = 5'h07;
  localparam logic [4:0] OP_SENSE_INT  = 5'h08;
  localparam logic [4:0] OP_SPECIFY    = 5'h03;
  localparam logic [4:0] OP_SENSE_DRV  = 5'h04;
  localparam logic [4:0] OP_SEEK       = 5'h0f;
  localparam int         CLK_PERIOD_NS = 4;
  localparam int         READY_GAP_NS  = 8;
  localparam int         READY_GAP_CYC = (READY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } io_req_type;

  typedef struct packed {
    logic [3:0] motor_en;
    logic       sel_cd;
    logic       sel_ab;
  } drive_ctrl_type;

  typedef enum logic [2:0] {
    ST_CMD  = 3'b001,
    ST_EXEC = 3'b010,
    ST_RES  = 3'b100
  } phase_type;
endpackage : floppy_port_pkg

// ---- src/floppy_host_register_port.sv ----
/*
  floppy host register port: address decode, control and rate registers,
  handshake status and the command / execution / result byte sequencer.
  assumes the host holds address and data stable while its strobe is high,
  and a floppy core on the same clock that executes commands and serves result bytes.
*/
`timescale 1ns/1ps
`default_nettype none
module floppy_host_register_port #(
  parameter int MAX_CMD_BYTES = 9
) (
  input  wire logic                           clk,            // 250 MHz
  input  wire logic                           rst,            // channel reset, sync high
  input  wire logic                           base_secondary, // strap pin, 1 = secondary base
  input  wire floppy_port_pkg::io_req_type    io,             // host address, data, strobes
  output var  logic [7:0]                     rdata,          // host read data
  output var  logic                           rdata_oe,       // drive host data bus
  output var  floppy_port_pkg::drive_ctrl_type drive,         // motors and selects
  output var  logic                           fdc_reset,      // floppy core held in reset
  output var  logic [1:0]                     data_rate,      // 00 500k, 01 300k, 10 250k
  input  wire logic                           core_irq,       // core interrupt request
  input  wire logic                           core_drq,       // core dma request
  output var  logic                           irq,            // gated interrupt to host
  output var  logic                           drq,            // gated dma request to host
  input  wire logic [1:0]                     seek_busy,      // bit1 drive B, bit0 drive A
  input  wire logic                           nondma_req,     // core moves data without dma
  output var  logic                           cmd_byte_valid, // one-cycle pulse
  output var  logic [7:0]                     cmd_byte,       // accepted command byte
  output var  logic [3:0]                     cmd_index,      // its position in the command
  output var  logic                           exec_start,     // one-cycle pulse
  output var  logic [4:0]                     exec_opcode,    // command code being executed
  input  wire logic                           exec_done,      // one-cycle pulse from core
  input  wire logic [1:0]                     exec_term,      // termination code with done
  output var  logic [2:0]                     res_index,      // result byte wanted from core
  input  wire logic [7:0]                     res_data        // result byte at res_index
);
  import floppy_port_pkg::*;

  initial
  begin
    if (MAX_CMD_BYTES < 9 || MAX_CMD_BYTES > 15)
      $error("MAX_CMD_BYTES must cover nine command bytes and fit four bits");
  end

  function automatic logic [3:0] cmd_len(input logic [4:0] op);
    case (op)
      OP_READ_DATA, OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: cmd_len = 4'h9;
      OP_FORMAT:                                        cmd_len = 4'h6;
      OP_SPECIFY, OP_SEEK:                              cmd_len = 4'h3;
      OP_RECAL, OP_SENSE_DRV:                           cmd_len = 4'h2;
      default:                                          cmd_len = 4'h1;
    endcase
  endfunction : cmd_len

  function automatic logic [2:0] res_len(input logic [4:0] op);
    case (op)
      OP_READ_DATA, OP_FORMAT, OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: res_len = 3'h7;
      OP_SENSE_INT: res_len = 3'h2;
      OP_SENSE_DRV: res_len = 3'h1;
      default:      res_len = 3'h0;
    endcase
  endfunction : res_len

  function automatic logic is_valid(input logic [4:0] op);
    case (op)
      OP_READ_DATA, OP_FORMAT, OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE,
      OP_RECAL, OP_SENSE_INT, OP_SPECIFY, OP_SENSE_DRV, OP_SEEK: is_valid = 1'b1;
      default: is_valid = 1'b0;
    endcase
  endfunction : is_valid

  // pin synchroniser: bit2 strap, bit1 write strobe, bit0 read strobe
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] lvl_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_reg  <= 3'h0;
      s2_reg  <= 3'h0;
      s3_reg  <= 3'h0;
      lvl_reg <= 3'h0;
    end
    else
    begin
      s1_reg <= {base_secondary, io.wr, io.rd};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < 3; i++)
        if (s2_reg[i] == s3_reg[i])
          lvl_reg[i] <= s3_reg[i];
    end
  end

  logic rd_evt;
  logic wr_evt;
  assign rd_evt = (s2_reg[0] == s3_reg[0]) && s3_reg[0] && !lvl_reg[0];
  assign wr_evt = (s2_reg[1] == s3_reg[1]) && s3_reg[1] && !lvl_reg[1];

  logic hit_ctrl;
  logic hit_status;
  logic hit_data;
  logic hit_rate;
  assign hit_ctrl   = io.addr == (lvl_reg[2] ? SEC_CTRL_ADDR : PRI_CTRL_ADDR);
  assign hit_status = io.addr == (lvl_reg[2] ? SEC_STATUS_ADDR : PRI_STATUS_ADDR);
  assign hit_data   = io.addr == (lvl_reg[2] ? SEC_DATA_ADDR : PRI_DATA_ADDR);
  assign hit_rate   = io.addr == (lvl_reg[2] ? SEC_RATE_ADDR : PRI_RATE_ADDR);

  logic [7:0] ctrl_reg;
  logic [1:0] rate_reg;

  // both registers are write-only; reads of their addresses are not answered
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_reg <= CTRL_RESET;
    else if (wr_evt && hit_ctrl)
      ctrl_reg <= io.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rate_reg <= RATE_RESET;
    else if (wr_evt && hit_rate)
      rate_reg <= io.wdata[1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive     <= '0;
      fdc_reset <= 1'b1;
      data_rate <= RATE_RESET;
      irq       <= 1'b0;
      drq       <= 1'b0;
    end
    else
    begin
      drive.motor_en <= ctrl_reg[7:4];
      drive.sel_cd   <= ctrl_reg[1];
      drive.sel_ab   <= ctrl_reg[0];
      fdc_reset      <= !ctrl_reg[CTRL_RUN_BIT];
      data_rate      <= rate_reg;
      irq            <= core_irq && ctrl_reg[CTRL_DMAEN_BIT];
      drq            <= core_drq && ctrl_reg[CTRL_DMAEN_BIT];
    end
  end

  phase_type  state_reg;
  logic       ready_reg;
  logic [1:0] gap_reg;
  logic [3:0] idx_reg;
  logic [3:0] need_reg;
  logic [4:0] op_reg;
  logic [2:0] res_total_reg;
  logic [1:0] term_reg;
  logic       invalid_reg;

  logic       dir_now;
  logic       data_wr_ok;
  logic       data_rd_ok;
  logic       data_bad;
  logic [3:0] len_now;
  logic [7:0] status_now;
  logic [7:0] res_byte_now;

  assign dir_now    = state_reg == ST_RES;
  assign data_wr_ok = wr_evt && hit_data && ready_reg && !dir_now;
  assign data_rd_ok = rd_evt && hit_data && ready_reg && dir_now;
  assign data_bad   = (wr_evt || rd_evt) && hit_data && !data_wr_ok && !data_rd_ok;
  assign len_now    = (idx_reg == 4'h0) ? cmd_len(io.wdata[4:0]) : need_reg;
  // bits 3 and 2 read as zero
  assign status_now = {ready_reg, dir_now,
                       nondma_req && (state_reg == ST_EXEC),
                       state_reg == ST_EXEC, 2'b00, seek_busy};
  assign res_byte_now = (res_index != 3'h0) ? res_data :
                        invalid_reg ? {term_reg, 6'h00} : {term_reg, res_data[5:0]};

  // the byte sequencer; a core reset pulls it back to the command phase
  always_ff @(posedge clk)
  begin
    if (rst || fdc_reset)
    begin
      state_reg      <= ST_CMD;
      idx_reg        <= 4'h0;
      need_reg       <= 4'h0;
      op_reg         <= 5'h00;
      res_total_reg  <= 3'h0;
      term_reg       <= normal_completion;
      invalid_reg    <= 1'b0;
      res_index      <= 3'h0;
      exec_start     <= 1'b0;
      exec_opcode    <= 5'h00;
      cmd_byte_valid <= 1'b0;
      cmd_byte       <= 8'h00;
      cmd_index      <= 4'h0;
    end
    else
    begin
      exec_start     <= 1'b0;
      cmd_byte_valid <= 1'b0;
      case (state_reg)
        ST_CMD:
        begin
          if (data_wr_ok)
          begin
            cmd_byte_valid <= 1'b1;
            cmd_byte       <= io.wdata;
            cmd_index      <= idx_reg;
            if (idx_reg == 4'h0)
            begin
              op_reg   <= io.wdata[4:0];
              need_reg <= len_now;
            end
            if (idx_reg + 4'h1 == len_now)
            begin
              idx_reg <= 4'h0;
              if (idx_reg == 4'h0 && !is_valid(io.wdata[4:0]))
              begin
                invalid_reg   <= 1'b1;
                term_reg      <= INVALID_CODE;
                res_total_reg <= 3'h1;
                res_index     <= 3'h0;
                state_reg     <= ST_RES;
              end
              else
              begin
                invalid_reg <= 1'b0;
                exec_start  <= 1'b1;
                exec_opcode <= (idx_reg == 4'h0) ? io.wdata[4:0] : op_reg;
                state_reg   <= ST_EXEC;
              end
            end
            else
              idx_reg <= idx_reg + 4'h1;
          end
        end
        ST_EXEC:
        begin
          if (exec_done)
          begin
            term_reg      <= exec_term;
            res_total_reg <= res_len(op_reg);
            res_index     <= 3'h0;
            state_reg     <= (res_len(op_reg) == 3'h0) ? ST_CMD : ST_RES;
          end
        end
        ST_RES:
        begin
          if (data_rd_ok)
          begin
            if (res_index + 3'h1 == res_total_reg)
            begin
              res_index <= 3'h0;
              state_reg <= ST_CMD;
            end
            else
              res_index <= res_index + 3'h1;
          end
        end
        default:
          state_reg <= ST_CMD;
      endcase
    end
  end

  // ready drops on each accepted byte and returns after a short gap;
  // it stays low through execution since data moves by the core there
  always_ff @(posedge clk)
  begin
    if (rst || fdc_reset)
    begin
      ready_reg <= 1'b1;
      gap_reg   <= 2'h0;
    end
    else if (data_wr_ok || data_rd_ok)
    begin
      ready_reg <= 1'b0;
      gap_reg   <= 2'(READY_GAP_CYC);
    end
    else if (gap_reg != 2'h0)
      gap_reg <= gap_reg - 2'h1;
    else
      ready_reg <= state_reg != ST_EXEC;
  end

  // read port answers status and data; unmapped reads leave the bus alone
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata    <= 8'h00;
      rdata_oe <= 1'b0;
    end
    else if (rd_evt && hit_status)
    begin
      rdata    <= status_now;
      rdata_oe <= 1'b1;
    end
    else if (rd_evt && hit_data)
    begin
      rdata    <= data_rd_ok ? res_byte_now : 8'h00;
      rdata_oe <= 1'b1;
    end
    else if (!lvl_reg[0] || !s3_reg[0])
      rdata_oe <= 1'b0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ctrl_write;
    wr_evt && hit_ctrl;
  endsequence

  sequence s_byte_taken;
    data_wr_ok || data_rd_ok;
  endsequence

  property p_ready_drops;
    s_byte_taken |=> !ready_reg [*2];
  endproperty
  a_ready_drops: assert property (p_ready_drops) else $error("ready did not drop");

  property p_status_ready;
    rd_evt && hit_status |=> rdata[STAT_READY_BIT] == $past(ready_reg);
  endproperty
  a_status_ready: assert property (p_status_ready) else $error("status ready wrong");

  property p_dir;
    rd_evt && hit_status |=> rdata[STAT_DIR_BIT] == ($past(state_reg) == ST_RES);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");

  property p_nondma;
    rd_evt && hit_status && state_reg != ST_EXEC |=> !rdata[STAT_NONDMA_BIT];
  endproperty
  a_nondma: assert property (p_nondma) else $error("non-dma outside execution");

  property p_busy;
    exec_start |-> state_reg == ST_EXEC && !ready_reg ##1 !ready_reg;
  endproperty
  a_busy: assert property (p_busy) else $error("not busy after start");

  property p_motor;
    s_ctrl_write |-> ##2 drive.motor_en == $past(io.wdata[7:4], 2);
  endproperty
  a_motor: assert property (p_motor) else $error("motor enables wrong");

  property p_gate;
    !ctrl_reg[CTRL_DMAEN_BIT] |=> !irq && !drq;
  endproperty
  a_gate: assert property (p_gate) else $error("request not gated");

  property p_core_reset;
    s_ctrl_write ##1 !ctrl_reg[CTRL_RUN_BIT] |=> fdc_reset ##1 state_reg == ST_CMD;
  endproperty
  a_core_reset: assert property (p_core_reset) else $error("core reset not held");

  property p_chan_reset;
    disable iff (1'b0) rst |=> ctrl_reg == CTRL_RESET && rate_reg == RATE_RESET;
  endproperty
  a_chan_reset: assert property (p_chan_reset) else $error("reset left bits");

  property p_ignore;
    data_bad && !exec_done |=> $stable(idx_reg) && $stable(res_index) && $stable(state_reg);
  endproperty
  a_ignore: assert property (p_ignore) else $error("bad access advanced");

  property p_first_code;
    data_rd_ok && res_index == 3'h0 |=> rdata[7:6] == $past(term_reg);
  endproperty
  a_first_code: assert property (p_first_code) else $error("termination code wrong");
endmodule : floppy_host_register_port
`default_nettype wire

// ---- bench/floppy_core_model.sv ----
/*
  floppy core stand-in behind the host register port: counts command bytes and
  starts, ends execution a fixed wait after each start, serves result bytes.
  assumes the port's clock and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module floppy_core_model (
  input  wire logic       clk,            // port clock
  input  wire logic       rst,            // sync reset
  input  wire logic       cmd_byte_valid, // command byte pulse
  input  wire logic       exec_start,     // start pulse
  input  wire logic [2:0] res_index,      // wanted result byte
  input  wire logic [1:0] term,           // code to report at the end
  output var  logic       exec_done,      // end pulse
  output var  logic [1:0] exec_term,      // code, valid with done
  output var  logic [7:0] res_data,       // result byte
  output var  int         n_cmd,          // command bytes seen
  output var  int         n_exec          // starts seen
);
  int wait_cnt;
  // pattern follows the index so a stuck index cannot pass
  assign res_data  = {~res_index[1:0], 3'b011, res_index};
  // the code is only good with done; show its inverse otherwise
  assign exec_term = exec_done ? term : ~term;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wait_cnt  <= 0;
      n_cmd     <= 0;
      n_exec    <= 0;
      exec_done <= 1'b0;
    end
    else
    begin
      exec_done <= (wait_cnt == 1);
      if (cmd_byte_valid)
        n_cmd <= n_cmd + 1;
      if (exec_start)
      begin
        n_exec   <= n_exec + 1;
        wait_cnt <= 60;
      end
      else if (wait_cnt != 0)
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : floppy_core_model
`default_nettype wire

// ---- bench/tb.sv ----
/*
  self-checking bench for the floppy host register port: host read/write tasks,
  command/result sequences for every opcode, control, rate and decode checks.
  assumes floppy_core_model on the core side.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import floppy_port_pkg::*;
  logic           clk            = 1'b0;
  logic           rst            = 1'b1;
  logic           base_secondary = 1'b0;
  io_req_type     io             = '0;
  logic           core_irq       = 1'b0;
  logic           core_drq       = 1'b0;
  logic [1:0]     seek_busy      = 2'b10;
  logic           nondma_req     = 1'b1;
  logic [1:0]     term           = 2'h0;
  logic [7:0]     rdata;
  logic           rdata_oe;
  drive_ctrl_type drive;
  logic           fdc_reset;
  logic [1:0]     data_rate;
  logic           irq;
  logic           drq;
  logic           cmd_byte_valid;
  logic [7:0]     cmd_byte;
  logic [3:0]     cmd_index;
  logic           exec_start;
  logic [4:0]     exec_opcode;
  logic           exec_done;
  logic [1:0]     exec_term;
  logic [2:0]     res_index;
  logic [7:0]     res_data;
  int             n_cmd;
  int             n_exec;
  int             n_fail         = 0;
  int             n_tests        = 0;
  logic [4:0]     ops [10]       = '{OP_READ_DATA, OP_FORMAT, OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE,
                                     OP_RECAL, OP_SENSE_INT, OP_SPECIFY, OP_SENSE_DRV, OP_SEEK};
  int             ncmd [10]      = '{9, 6, 9, 9, 9, 2, 1, 3, 2, 3};
  int             nres [10]      = '{7, 7, 7, 7, 7, 0, 2, 0, 1, 0};
  logic [7:0]     s;
  logic           got;

  always #2 clk = ~clk;

  floppy_host_register_port DUT (
    .clk(clk), .rst(rst), .base_secondary(base_secondary), .io(io), .rdata(rdata), .rdata_oe(rdata_oe),
    .drive(drive), .fdc_reset(fdc_reset), .data_rate(data_rate), .core_irq(core_irq), .core_drq(core_drq),
    .irq(irq), .drq(drq), .seek_busy(seek_busy), .nondma_req(nondma_req), .cmd_byte_valid(cmd_byte_valid),
    .cmd_byte(cmd_byte), .cmd_index(cmd_index), .exec_start(exec_start), .exec_opcode(exec_opcode),
    .exec_done(exec_done), .exec_term(exec_term), .res_index(res_index), .res_data(res_data));

  floppy_core_model core (
    .clk(clk), .rst(rst), .cmd_byte_valid(cmd_byte_valid), .exec_start(exec_start), .res_index(res_index),
    .term(term), .exec_done(exec_done), .exec_term(exec_term), .res_data(res_data), .n_cmd(n_cmd),
    .n_exec(n_exec));

  task automatic complete_run();
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // strobe held long enough for the three-flop synchroniser, then low >= 3 clocks
  task automatic io_write(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    io <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    repeat (6) @(posedge clk);
    io.wr <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : io_write

  task automatic io_read(input logic [9:0] a, output logic [7:0] d, output logic g);
    g = 1'b0;
    d = 8'h00;
    @(posedge clk);
    io <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    repeat (10)
    begin
      @(posedge clk);
      #1;
      if (rdata_oe === 1'b1 && !g)
      begin
        g = 1'b1;
        d = rdata;
      end
    end
    @(posedge clk);
    io.rd <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : io_read

  task automatic wait_ready(input logic dir);
    logic [7:0] st;
    logic       g;
    int         n;
    st = 8'h00;
    n = 0;
    while (!(st[7] === 1'b1 && st[6] === dir) && n < 40)
    begin
      io_read(PRI_STATUS_ADDR, st, g);
      n++;
    end
    check("ready and direction", {st[7:6], 6'h0}, {1'b1, dir, 6'h0});
  endtask : wait_ready

  function automatic logic [7:0] pat(input int k);
    logic [2:0] i;
    i = 3'(k);
    return {~i[1:0], 3'b011, i};
  endfunction : pat

  task automatic run_cmd(input logic [4:0] op, input int nc, input int nr, input logic [1:0] tm, input bit inv);
    logic [7:0] d;
    logic [7:0] b;
    logic       g;
    int         c0;
    int         e0;
    term = tm;
    c0 = n_cmd;
    e0 = n_exec;
    for (int k = 0; k < nc; k++)
    begin
      b = (k == 0) ? {3'b010, op} : 8'(k);
      wait_ready(1'b0);
      io_write(PRI_DATA_ADDR, b);
      check("command byte", cmd_byte, b);
      check("command index", 8'(cmd_index), 8'(k));
    end
    check("command bytes", 8'(n_cmd - c0), 8'(nc));
    if (inv)
    begin
      check("starts", 8'(n_exec - e0), 8'h00);
      wait_ready(1'b1);
      io_read(PRI_DATA_ADDR, d, g);
      check("invalid result", d, 8'h80);
    end
    else
    begin
      check("starts", 8'(n_exec - e0), 8'h01);
      check("opcode", 8'(exec_opcode), 8'(op));
      io_read(PRI_STATUS_ADDR, d, g);
      check("exec status", d & 8'hb0, 8'h30);
      for (int k = 0; k < nr; k++)
      begin
        wait_ready(1'b1);
        io_read(PRI_DATA_ADDR, d, g);
        check("result", d, (k == 0) ? {tm, 6'(pat(0))} : pat(k));
      end
    end
    wait_ready(1'b0);
    io_read(PRI_STATUS_ADDR, d, g);
    check("idle status", d, {6'h20, seek_busy});
  endtask : run_cmd

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("fdc_reset", 8'(fdc_reset), 8'h01);
    check("drive", 8'(drive), 8'h00);
    check("rate", 8'(data_rate), 8'h00);
    io_write(PRI_CTRL_ADDR, 8'h5d);
    check("drive", 8'(drive), 8'h15);
    check("fdc_reset", 8'(fdc_reset), 8'h00);
    core_irq <= 1'b1;
    core_drq <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("irq drq", 8'({irq, drq}), 8'h03);
    io_write(PRI_CTRL_ADDR, 8'ha6);
    check("drive", 8'(drive), 8'h2a);
    check("irq drq", 8'({irq, drq}), 8'h00);
    io_read(PRI_CTRL_ADDR, s, got);
    check("control read", 8'(got), 8'h00);
    io_read(10'h3f3, s, got);
    check("unmapped read", 8'(got), 8'h00);
    for (int r = 0; r < 4; r++)
    begin
      io_write(PRI_RATE_ADDR, 8'hfc | 8'(r));
      check("rate", 8'(data_rate), 8'(r));
    end
    io_read(PRI_RATE_ADDR, s, got);
    check("rate read", 8'(got), 8'h00);
    io_read(PRI_STATUS_ADDR, s, got);
    check("status", s, 8'h82);
    seek_busy <= 2'b01;
    io_read(PRI_STATUS_ADDR, s, got);
    check("status", s, 8'h81);
    io_read(PRI_DATA_ADDR, s, got);
    check("wrong direction read", s, 8'h00);
    for (int i = 0; i < 10; i++)
      run_cmd(ops[i], ncmd[i], nres[i], (i % 2 == 0) ? normal_completion : abrupt_completion, 1'b0);
    run_cmd(5'h1f, 1, 1, 2'h0, 1'b1);
    // a core reset in mid-command must drop the half-written opcode
    io_write(PRI_DATA_ADDR, {3'b010, OP_SEEK});
    io_write(PRI_CTRL_ADDR, 8'h10);
    check("fdc_reset", 8'(fdc_reset), 8'h01);
    check("drive", 8'(drive), 8'h04);
    io_write(PRI_CTRL_ADDR, 8'h14);
    run_cmd(OP_SEEK, 3, 0, normal_completion, 1'b0);
    base_secondary <= 1'b1;
    repeat (6) @(posedge clk);
    io_write(SEC_CTRL_ADDR, 8'h17);
    check("drive", 8'(drive), 8'h07);
    io_read(SEC_STATUS_ADDR, s, got);
    check("secondary status", s, 8'h81);
    io_read(PRI_STATUS_ADDR, s, got);
    check("primary unused", 8'(got), 8'h00);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("drive", 8'(drive), 8'h00);
    check("rate", 8'(data_rate), 8'h00);
    check("fdc_reset", 8'(fdc_reset), 8'h01);
    complete_run();
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
